// file: logic/power_state_wake_reset_ctrl.sv
// Purpose: power-state, clock gating, sleep timer and reset merging
// Assumes: inputs synchronous to I_CLK; I_RESETN is the power-on reset
// Notes: low-speed domain is a 32 kHz enable pulse from a divider
`include "pwr_cfg.svh"
module power_state_wake_reset_ctrl
  import pwr_pkg::*;
#(
  parameter int LF_DIV = `LF_DIV_CYCLES,
  parameter int RESTORE = `WAKE_RESTORE_CYCLES,
  parameter int TW = 32
) (
  // clock and resets
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_EXT_RESET_N,
  input wire logic I_BROWNOUT,
  input wire logic I_WDT_EXPIRE,
  // core side
  input wire logic I_WAIT_FOR_IRQ_INSTR,
  input wire logic I_DEEP_SEL,
  input wire logic [1:0] I_RUN_MODE,
  input wire logic [TW-1:0] I_SLEEP_INTERVAL,
  input wire logic I_LF_HF_CRYSTAL_OSC_SEL,
  input wire logic [3:0] I_SYSCLK_DIV,
  // wake pins
  input wire logic [7:0] I_WAKE_PORT_A,
  input wire logic [7:0] I_WAKE_PORT_B,
  input wire logic [15:0] I_WAKE_PORT_HI,
  // outputs
  output logic O_SYS_RESET_N,
  output logic O_CPU_CLK_EN,
  output logic O_CPU_RUN,
  output logic O_WAKE_IRQ,
  output logic O_DIG_REG_ON,
  output logic O_LF_HF_CRYSTAL_OSC_EN,
  output logic O_LF_RC_EN,
  output logic O_SLEEP_TMR_ON,
  output logic O_RADIO_PWR,
  output logic O_HF_CRYSTAL_OSC_EN,
  output logic O_SYSCLK_EN,
  output logic [TW-1:0] O_SLEEP_COUNT,
  output logic [2:0] O_PWR_STATE
);
  logic src_n;
  logic rst_n;
  // watchdog, brownout, pin and power-on all reset the system
  assign src_n = I_RESETN & I_EXT_RESET_N & ~I_BROWNOUT & ~I_WDT_EXPIRE;
  reset_merge #(.STAGES(`RST_SYNC_STAGES)) u_rst (
    .clk(I_CLK),
    .src_n(src_n),
    .rst_n(rst_n)
  );
  // last stage of the release chain; any source pulls it low at once
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_SYS_RESET_N <= 1'b0;
    end else begin
      O_SYS_RESET_N <= 1'b1;
    end
  end

  pwr_state_t state_q;
  logic [15:0] lf_cnt_q;
  logic lf_tick_q;
  logic [TW-1:0] tmr_q;
  logic [15:0] pins_q;
  logic pin_wake;
  logic tmr_done;
  logic [4:0] restore_q;
  logic [3:0] div_cnt_q;
  logic lf_on;

  assign lf_on = (state_q != ST_DEEP);
  // low-speed enable pulse; stopped in deep sleep with the oscillator
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lf_cnt_q <= 16'h0000;
      lf_tick_q <= 1'b0;
    end else if (!lf_on) begin
      lf_cnt_q <= 16'h0000;
      lf_tick_q <= 1'b0;
    end else if (lf_cnt_q == 16'(LF_DIV - 1)) begin
      lf_cnt_q <= 16'h0000;
      lf_tick_q <= 1'b1;
    end else begin
      lf_cnt_q <= lf_cnt_q + 16'h0001;
      lf_tick_q <= 1'b0;
    end
  end

  // sleep timer counts at the 32 kHz rate only in sleep
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= `TIMER_RESET;
    end else if (state_q != ST_SLEEP) begin
      tmr_q <= `TIMER_RESET;
    end else if (lf_tick_q && !tmr_done) begin
      tmr_q <= tmr_q + 32'(1);
    end
  end
  assign tmr_done = (tmr_q >= I_SLEEP_INTERVAL);

  // pin sampling on the always-on path, independent of the gated core clock
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pins_q <= 16'h0000;
    end else begin
      pins_q <= {I_WAKE_PORT_B, I_WAKE_PORT_A};
    end
  end
  // upper port bits are deliberately not part of the wake term
  assign pin_wake = |pins_q;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_ACTIVE;
      restore_q <= 5'h00;
    end else begin
      case (state_q)
        ST_ACTIVE, ST_IDLE, ST_RADIO: begin
          if (I_WAIT_FOR_IRQ_INSTR) begin
            state_q <= I_DEEP_SEL ? ST_DEEP : ST_SLEEP;
          end else begin
            case (run_mode_t'(I_RUN_MODE))
              REQ_IDLE: state_q <= ST_IDLE;
              REQ_RADIO: state_q <= ST_RADIO;
              default: state_q <= ST_ACTIVE;
            endcase
          end
        end
        ST_SLEEP: begin
          if (pin_wake || tmr_done) begin
            state_q <= ST_WAKE;
            restore_q <= 5'h00;
          end
        end
        ST_DEEP: begin
          if (pin_wake) begin
            state_q <= ST_WAKE;
            restore_q <= 5'h00;
          end
        end
        ST_WAKE: begin
          if (restore_q == 5'(RESTORE - 1)) begin
            state_q <= ST_ACTIVE;
          end else begin
            restore_q <= restore_q + 5'h01;
          end
        end
        default: state_q <= ST_ACTIVE;
      endcase
    end
  end

  // system clock divider enable: I_CLK divided by I_SYSCLK_DIV+1
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= `SYSDIV_RESET;
      O_SYSCLK_EN <= 1'b0;
    end else if (div_cnt_q >= I_SYSCLK_DIV) begin
      div_cnt_q <= 4'h0;
      O_SYSCLK_EN <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
      O_SYSCLK_EN <= 1'b0;
    end
  end

  // outputs registered from next state for same-cycle gating
  pwr_state_t nxt;
  always_comb begin
    nxt = state_q;
    if ((state_q == ST_ACTIVE || state_q == ST_IDLE || state_q == ST_RADIO)
        && I_WAIT_FOR_IRQ_INSTR) begin
      nxt = I_DEEP_SEL ? ST_DEEP : ST_SLEEP;
    end
  end
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_CPU_CLK_EN <= 1'b1;
      O_CPU_RUN <= 1'b1;
      O_WAKE_IRQ <= 1'b0;
      O_DIG_REG_ON <= 1'b1;
      O_LF_HF_CRYSTAL_OSC_EN <= 1'b0;
      O_LF_RC_EN <= 1'b1;
      O_SLEEP_TMR_ON <= 1'b1;
      O_RADIO_PWR <= 1'b0;
      O_HF_CRYSTAL_OSC_EN <= 1'b1;
      O_SLEEP_COUNT <= `TIMER_RESET;
      O_PWR_STATE <= 3'b000;
    end else begin
      O_CPU_CLK_EN <= (nxt != ST_SLEEP) && (nxt != ST_DEEP);
      O_CPU_RUN <= (nxt == ST_ACTIVE) || (nxt == ST_RADIO);
      // notice lines up with the state output turning active and the core running
      O_WAKE_IRQ <= (O_PWR_STATE == ST_WAKE) && (state_q == ST_ACTIVE);
      O_DIG_REG_ON <= (nxt != ST_SLEEP) && (nxt != ST_DEEP);
      O_LF_HF_CRYSTAL_OSC_EN <= (nxt != ST_DEEP) && I_LF_HF_CRYSTAL_OSC_SEL;
      O_LF_RC_EN <= (nxt != ST_DEEP) && !I_LF_HF_CRYSTAL_OSC_SEL;
      O_SLEEP_TMR_ON <= (nxt != ST_DEEP);
      O_RADIO_PWR <= (nxt == ST_RADIO);
      O_HF_CRYSTAL_OSC_EN <= (nxt != ST_SLEEP) && (nxt != ST_DEEP);
      O_SLEEP_COUNT <= tmr_q;
      O_PWR_STATE <= nxt;
    end
  end

  property p_deep_no_timer;
    @(posedge I_CLK) disable iff (!rst_n)
      (state_q == ST_DEEP && !pin_wake) |=> (state_q == ST_DEEP);
  endproperty
  a_deep_no_timer: assert property (p_deep_no_timer) else $error("deep sleep left");

  property p_gate;
    @(posedge I_CLK) disable iff (!rst_n)
      (state_q == ST_ACTIVE && I_WAIT_FOR_IRQ_INSTR) |=> !O_CPU_CLK_EN;
  endproperty
  a_gate: assert property (p_gate) else $error("clock not gated");

  property p_restore;
    @(posedge I_CLK) disable iff (!rst_n)
      ((state_q == ST_SLEEP && (pin_wake || tmr_done)) || (state_q == ST_DEEP && pin_wake))
      |=> (state_q == ST_WAKE)[*8] ##1 (state_q == ST_WAKE)[*8] ##1 (state_q == ST_ACTIVE);
  endproperty
  a_restore: assert property (p_restore) else $error("restore length wrong");

  property p_wake_clk;
    @(posedge I_CLK) disable iff (!rst_n)
      (state_q == ST_DEEP && pin_wake) |=> ##1 O_CPU_CLK_EN && !O_CPU_RUN;
  endproperty
  a_wake_clk: assert property (p_wake_clk) else $error("clock not restored");

  property p_one_lf;
    @(posedge I_CLK) disable iff (!rst_n)
      !(O_LF_HF_CRYSTAL_OSC_EN && O_LF_RC_EN);
  endproperty
  a_one_lf: assert property (p_one_lf) else $error("both low-speed sources on");

  property p_deep_off;
    @(posedge I_CLK) disable iff (!rst_n)
      (O_PWR_STATE == 3'b100) |-> !O_DIG_REG_ON && !O_SLEEP_TMR_ON && !O_LF_RC_EN;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("deep sleep power wrong");

  property p_sleep_pwr;
    @(posedge I_CLK) disable iff (!rst_n)
      (O_PWR_STATE == 3'b011) |-> !O_DIG_REG_ON && O_SLEEP_TMR_ON;
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep power wrong");

  property p_radio;
    @(posedge I_CLK) disable iff (!rst_n)
      O_RADIO_PWR |-> O_DIG_REG_ON && O_SLEEP_TMR_ON && O_PWR_STATE == 3'b010;
  endproperty
  a_radio: assert property (p_radio) else $error("radio power wrong");

  property p_wdt_rst;
    @(posedge I_CLK) disable iff (!I_RESETN)
      I_WDT_EXPIRE |=> ##1 !O_SYS_RESET_N;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset missing");
endmodule

// file: logic/pwr_cfg.svh
// Purpose: timing, reset values and sync depth for the power and wake controller
// Assumes: one 200 MHz clock; 32 kHz ticks come from a divider on that clock
// Notes: Function
// Function
// - on the wait-for-interrupt instruction the core halts, sleep is entered and its clock is gated at once.
// - deep sleep ends only on an external interrupt, never on the sleep timer.
// - an external interrupt or sleep timer expiry turns the core clock back on.
// - sixteen cycles pass after the clock returns before the core resumes and takes its interrupt.
// - only the low eight pins of port a and port b may wake the chip; all others are ignored.
// - deep sleep turns off regulator, low-speed oscillator and sleep timer while retaining memory.
// - sleep turns off the regulator, keeps oscillator and timer running, and ends on timer expiry.
// - idle, active and radio keep regulator, oscillator and timer on; radio powers only in radio.
// - exactly one of the low-speed crystal and the low-speed rc oscillator is enabled; the code turns both off in deep sleep.
// - the system clock is the 32 MHz reference or an integer division of it; the code divides its one 200 MHz clock instead.
// - reset pin low, power-on, brownout or watchdog expiry each cause a system reset.
// - the sleep timer is a 32-bit counter at the 32 kHz rate in the always-on domain.
// - the power management unit switches each region's supply according to the power state.
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH
`define CLK_FREQ_HZ 200000000
`define LF_FREQ_HZ 32000
`define LF_DIV_CYCLES (`CLK_FREQ_HZ / `LF_FREQ_HZ)
`define WAKE_RESTORE_CYCLES 16
`define SYSDIV_RESET 4'h0
`define TIMER_RESET 32'h0000_0000
`define RST_SYNC_STAGES 2
`endif

// file: logic/pwr_pkg.sv
package pwr_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_IDLE = 3'b001,
    ST_RADIO = 3'b010,
    ST_SLEEP = 3'b011,
    ST_DEEP = 3'b100,
    ST_WAKE = 3'b101
  } pwr_state_t;
  typedef enum logic [1:0] {
    REQ_ACTIVE = 2'b00,
    REQ_IDLE = 2'b01,
    REQ_RADIO = 2'b10
  } run_mode_t;
endpackage

// file: logic/reset_merge.sv
// Purpose: merge reset sources into one system reset
// Assumes: all source inputs are active low
// Notes: release after all sources clear, synchronised to the clock
`include "pwr_cfg.svh"
module reset_merge #(
  parameter int STAGES = `RST_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic src_n,
  output logic rst_n
);
  logic [STAGES-1:0] sync_q;
  // any source clears the chain at once, release walks through the chain
  always_ff @(posedge clk or negedge src_n) begin
    if (!src_n) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = sync_q[STAGES-1];
endmodule

// file: testbench/core_pin_model.sv
// Purpose: core, wake pin and reset pin side of the power controller
// Assumes: every change lands just after a rising clock edge
// Notes: tasks are called from the bench; idle wake pins sit low, the reset pin high
module core_pin_model (
  input wire logic clk,
  output logic wait_for_irq_instr,
  output logic deep_sel,
  output logic [31:0] interval,
  output logic lf_hf_crystal_osc_sel,
  output logic [7:0] port_a,
  output logic [7:0] port_b,
  output logic [15:0] port_hi,
  output logic ext_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wait_for_irq_instr = 1'b0;
    deep_sel = 1'b0;
    interval = 32'h0000_0000;
    lf_hf_crystal_osc_sel = 1'b0;
    port_a = 8'h00;
    port_b = 8'h00;
    port_hi = 16'h0000;
    ext_reset_n = 1'b1;
  end
  // interval is set a cycle ahead of the wait-for-interrupt pulse
  task automatic sleep(input logic deep, input logic [31:0] ticks);
    @(posedge clk);
    #1;
    interval = ticks;
    deep_sel = deep;
    @(posedge clk);
    #1;
    wait_for_irq_instr = 1'b1;
    @(posedge clk);
    #1;
    wait_for_irq_instr = 1'b0;
  endtask
  // one-cycle high level on a pin: 0-7 port a, 8-15 port b, above that high pins
  task automatic pin(input int idx);
    @(posedge clk);
    #1;
    if (idx < 8) port_a[idx] = 1'b1;
    else if (idx < 16) port_b[idx-8] = 1'b1;
    else port_hi[idx-16] = 1'b1;
    @(posedge clk);
    #1;
    port_a = 8'h00;
    port_b = 8'h00;
    port_hi = 16'h0000;
  endtask
endmodule

// file: testbench/tb_power_state_wake_reset_ctrl.sv
// Purpose: self-checking bench for the power, wake and reset controller
// Assumes: low-speed tick shortened to every 4 clocks
// Notes: inputs change 1 ns after the rising edge
module tb_power_state_wake_reset_ctrl;
  import pwr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RESTORE_C = 16;
  logic I_CLK;
  logic I_RESETN;
  logic I_BROWNOUT;
  logic I_WDT_EXPIRE;
  logic [1:0] I_RUN_MODE;
  logic [3:0] I_SYSCLK_DIV;
  logic wait_for_irq_instr, deep_sel, lf_sel, ext_n;
  logic [31:0] interval;
  logic [7:0] pa, pb;
  logic [15:0] phi;
  logic O_SYS_RESET_N, O_CPU_CLK_EN, O_CPU_RUN, O_WAKE_IRQ, O_DIG_REG_ON, O_LF_HF_CRYSTAL_OSC_EN;
  logic O_LF_RC_EN, O_SLEEP_TMR_ON, O_RADIO_PWR, O_HF_CRYSTAL_OSC_EN, O_SYSCLK_EN;
  logic [31:0] O_SLEEP_COUNT;
  logic [2:0] O_PWR_STATE;
  int errors = 0;
  int comparisons = 0;
  always #2.5 I_CLK = ~I_CLK;
  core_pin_model core_u (.clk(I_CLK), .wait_for_irq_instr(wait_for_irq_instr), .deep_sel(deep_sel), .interval(interval),
    .lf_hf_crystal_osc_sel(lf_sel), .port_a(pa), .port_b(pb), .port_hi(phi), .ext_reset_n(ext_n));
  power_state_wake_reset_ctrl #(.LF_DIV(4), .RESTORE(RESTORE_C), .TW(32)) dut_u (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_EXT_RESET_N(ext_n), .I_BROWNOUT(I_BROWNOUT),
    .I_WDT_EXPIRE(I_WDT_EXPIRE), .I_WAIT_FOR_IRQ_INSTR(wait_for_irq_instr), .I_DEEP_SEL(deep_sel),
    .I_RUN_MODE(I_RUN_MODE), .I_SLEEP_INTERVAL(interval), .I_LF_HF_CRYSTAL_OSC_SEL(lf_sel),
    .I_SYSCLK_DIV(I_SYSCLK_DIV), .I_WAKE_PORT_A(pa), .I_WAKE_PORT_B(pb),
    .I_WAKE_PORT_HI(phi), .O_SYS_RESET_N(O_SYS_RESET_N), .O_CPU_CLK_EN(O_CPU_CLK_EN),
    .O_CPU_RUN(O_CPU_RUN), .O_WAKE_IRQ(O_WAKE_IRQ), .O_DIG_REG_ON(O_DIG_REG_ON),
    .O_LF_HF_CRYSTAL_OSC_EN(O_LF_HF_CRYSTAL_OSC_EN), .O_LF_RC_EN(O_LF_RC_EN), .O_SLEEP_TMR_ON(O_SLEEP_TMR_ON),
    .O_RADIO_PWR(O_RADIO_PWR), .O_HF_CRYSTAL_OSC_EN(O_HF_CRYSTAL_OSC_EN),
    .O_SYSCLK_EN(O_SYSCLK_EN), .O_SLEEP_COUNT(O_SLEEP_COUNT), .O_PWR_STATE(O_PWR_STATE));
  task automatic end_sim();
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic wait_state(input logic [2:0] s, input int bound);
    int n;
    n = 0;
    while (O_PWR_STATE !== s && n < bound) begin
      tick(1);
      n++;
    end
    if (O_PWR_STATE !== s) begin
      chk(O_PWR_STATE, s);
      end_sim();
    end
  endtask
  task automatic wake_seq(input int bound);
    int n;
    n = 0;
    wait_state(ST_WAKE, bound);
    chk(O_CPU_CLK_EN, 1);
    chk(O_CPU_RUN, 0);
    while (O_PWR_STATE === ST_WAKE && n < 40) begin
      tick(1);
      n++;
    end
    chk(n, RESTORE_C);
    chk({O_PWR_STATE, O_CPU_RUN, O_WAKE_IRQ}, {ST_ACTIVE, 2'b11});
    tick(1);
    chk(O_WAKE_IRQ, 0);
  endtask
  task automatic t_sleep();
    core_u.sleep(1'b0, 32'h0000_0003);
    wait_state(ST_SLEEP, 2);
    chk(O_CPU_CLK_EN, 0);
    chk({O_DIG_REG_ON, O_LF_RC_EN, O_SLEEP_TMR_ON}, 3'b011);
    wait_state(ST_WAKE, 400);
    chk(O_SLEEP_COUNT, 32'h0000_0003);
    wake_seq(1);
    core_u.sleep(1'b0, 32'hFFFF_FFFF);
    wait_state(ST_SLEEP, 2);
    core_u.pin(0);
    wake_seq(8);
  endtask
  task automatic t_deep();
    core_u.sleep(1'b1, 32'h0000_0002);
    wait_state(ST_DEEP, 2);
    chk(O_CPU_CLK_EN, 0);
    chk({O_DIG_REG_ON, O_LF_RC_EN, O_LF_HF_CRYSTAL_OSC_EN, O_SLEEP_TMR_ON}, 4'h0);
    tick(60);
    chk(O_PWR_STATE, ST_DEEP);
    chk(O_SLEEP_COUNT, 32'h0000_0000);
    core_u.pin(16);
    core_u.pin(31);
    tick(4);
    chk(O_PWR_STATE, ST_DEEP);
    core_u.pin(15);
    wake_seq(8);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      I_RUN_MODE = m[1:0];
      core_u.lf_hf_crystal_osc_sel = m[0];
      tick(3);
      chk(O_PWR_STATE, (m == 3) ? 3'd0 : m[2:0]);
      chk({O_DIG_REG_ON, O_SLEEP_TMR_ON, O_HF_CRYSTAL_OSC_EN}, 3'b111);
      chk(O_RADIO_PWR, m == 2);
      chk(O_CPU_RUN, m != 1);
      chk({O_LF_HF_CRYSTAL_OSC_EN, O_LF_RC_EN}, {m[0], !m[0]});
    end
    I_RUN_MODE = 2'b00;
    core_u.lf_hf_crystal_osc_sel = 1'b0;
    tick(3);
  endtask
  task automatic t_sysclk();
    int n;
    for (int d = 1; d < 16; d = d * 2) begin
      I_SYSCLK_DIV = 4'(d - 1);
      tick(8);
      n = 0;
      repeat (40) begin
        tick(1);
        n += O_SYSCLK_EN;
      end
      chk(n, 40 / d);
    end
  endtask
  task automatic t_resets();
    for (int s = 0; s < 3; s++) begin
      core_u.ext_reset_n = (s != 0);
      I_BROWNOUT = (s == 1);
      I_WDT_EXPIRE = (s == 2);
      #1;
      chk(O_SYS_RESET_N, 0);
      tick(3);
      chk(O_SYS_RESET_N, 0);
      core_u.ext_reset_n = 1'b1;
      I_BROWNOUT = 1'b0;
      I_WDT_EXPIRE = 1'b0;
      tick(1);
      chk(O_SYS_RESET_N, 0);
      tick(3);
      chk({O_SYS_RESET_N, O_PWR_STATE}, {1'b1, ST_ACTIVE});
    end
  endtask
  initial begin
    #100000;
    errors++;
    end_sim();
  end
  initial begin
    I_CLK = 1'b0;
    I_RESETN = 1'b0;
    I_BROWNOUT = 1'b0;
    I_WDT_EXPIRE = 1'b0;
    I_RUN_MODE = 2'b00;
    I_SYSCLK_DIV = 4'h0;
    tick(20);
    chk({O_SYS_RESET_N, O_CPU_CLK_EN, O_DIG_REG_ON, O_LF_RC_EN, O_RADIO_PWR}, 5'b01110);
    I_RESETN = 1'b1;
    tick(5);
    chk(O_SYS_RESET_N, 1);
    t_modes();
    t_sysclk();
    t_sleep();
    t_deep();
    t_resets();
    end_sim();
  end
endmodule
